/* File: rtl/rss_pkg.sv */
// constants, types and op codes of the rotate, subtract and power-down datapath
// ==========================================================================
// Overview of operation
// - rotate left moves the file register one place left through carry; destination 0 is the accumulator, 1 the file.
// - rotate left with destination 1 stores back into the file register and leaves the accumulator alone.
// - rotate right moves the file register one place right through carry; destination 0 is accumulator, 1 the file.
// - rotate instructions carry a seven-bit file address 0 to 127 and a one-bit destination selector; subtract uses an eight-bit literal.
// - power-down loads zero into the watchdog count and clears the watchdog prescaler.
// - power-down clears the active-low power-down flag, sets the active-low time-out flag and touches no other flag.
// - on the same edge as the flag update, power-down puts the core to sleep with the main oscillator halted.
// - subtract puts literal plus two's complement of accumulator in accumulator; updates carry, nibble carry, zero.
// - subtract carry is 1 when the accumulator is at most the literal and 0 when it is greater.
// - subtract nibble carry is 0 when the accumulator low nibble exceeds the literal low nibble, 1 otherwise.
package rss_pkg;
    // ======================================================================
    // register map, byte addresses
    localparam logic [11:0] OFF_INSTR = 12'h000;
    localparam logic [11:0] OFF_ACC = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_WDOG = 12'h00c;
    localparam logic [11:0] OFF_CTRL = 12'h010;
    localparam logic [2:0] FILE_WIN_SEL = 3'h1;
    // ======================================================================
    // instruction word fields
    localparam int OP_LSB = 0;
    localparam int DEST_BIT = 7;
    localparam int FADDR_LSB = 8;
    localparam int LIT_LSB = 16;
    // ======================================================================
    // status bits and reset value
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_PWRDN = 3;
    localparam int ST_TMOUT = 4;
    localparam logic [4:0] STATUS_RST = 5'h18;
    localparam logic [7:0] ACC_RST = 8'h00;
    // ======================================================================
    // control bits
    localparam int CTRL_WDOG_EN = 0;
    localparam int CTRL_WAKE = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        op_none = 3'h0,
        rotate_left_carry_op = 3'h1,
        rotate_right_carry_op = 3'h2,
        literal_minus_acc_op = 3'h3,
        power_down_op = 3'h4
    } rss_op_t;

    typedef enum logic [1:0] {
        core_run = 2'h1,
        core_sleep = 2'h2
    } rss_core_t;
endpackage : rss_pkg

/* File: rtl/rss_alu.sv */
// combinational result and flag logic for rotates and literal subtract
`timescale 1ns/1ps
`default_nettype none
module rss_alu (
    // operands
    input wire logic [2:0] op,
    input wire logic [7:0] file_val,
    input wire logic [7:0] acc,
    input wire logic [7:0] literal,
    input wire logic carry_in,
    // results
    output logic [7:0] result,
    output logic carry_out,
    output logic nibble_carry,
    output logic zero
);
    logic [8:0] diff;
    logic [4:0] low_diff;

    // w subtracted as k + ~w + 1 so the carry out is an inverted borrow
    assign diff = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
    assign low_diff = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

    always_comb begin
        result = file_val;
        carry_out = carry_in;
        case (rss_pkg::rss_op_t'(op))
            rss_pkg::rotate_left_carry_op: begin
                result = {file_val[6:0], carry_in};
                carry_out = file_val[7];
            end
            rss_pkg::rotate_right_carry_op: begin
                result = {carry_in, file_val[7:1]};
                carry_out = file_val[0];
            end
            rss_pkg::literal_minus_acc_op: begin
                result = diff[7:0];
                carry_out = diff[8];
            end
            default: begin
                result = file_val;
                carry_out = carry_in;
            end
        endcase
    end

    assign nibble_carry = low_diff[4];
    assign zero = (diff[7:0] == 8'h00);
endmodule : rss_alu
`default_nettype wire

/* File: rtl/rss_exec.sv */
// rotate, literal subtract and power-down execution unit behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module rss_exec #(
    parameter int FILE_DEPTH = 128,
    parameter int WDOG_W = 8,
    parameter int PRE_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // core power state
    output logic core_sleeping,
    output logic osc_enable
);
    // ======================================================================
    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction : merge

    // ======================================================================
    // bus holding registers
    logic [11:0] aw_addr_q;
    logic aw_held;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_held;
    logic do_write;
    logic [31:0] wr_word;
    logic hit_instr, hit_acc, hit_status, hit_wdog, hit_ctrl, hit_file, wr_hit;
    logic [6:0] wr_idx;
    logic rd_take;
    logic [31:0] rd_mux;
    logic rd_hit;

    // ======================================================================
    // architectural state
    logic [7:0] acc;
    logic [4:0] status;
    logic [7:0] file_reg [FILE_DEPTH];
    logic [WDOG_W-1:0] watchdog_counter;
    logic [PRE_W-1:0] wdog_prescaler;
    logic wdog_enable;
    rss_pkg::rss_core_t core_state;

    // ======================================================================
    // instruction decode and alu
    logic exec_valid;
    rss_pkg::rss_op_t exec_op;
    logic exec_dest;
    logic [6:0] exec_faddr;
    logic [7:0] exec_lit;
    logic exec_rotate;
    logic [7:0] alu_result;
    logic alu_carry, alu_nibble, alu_zero;

    assign do_write = aw_held && w_held && !bvalid;
    assign wr_word = merge(32'h0000_0000, w_data_q, w_strb_q);
    assign hit_instr = (aw_addr_q[11:2] == rss_pkg::OFF_INSTR[11:2]);
    assign hit_acc = (aw_addr_q[11:2] == rss_pkg::OFF_ACC[11:2]);
    assign hit_status = (aw_addr_q[11:2] == rss_pkg::OFF_STATUS[11:2]);
    assign hit_wdog = (aw_addr_q[11:2] == rss_pkg::OFF_WDOG[11:2]);
    assign hit_ctrl = (aw_addr_q[11:2] == rss_pkg::OFF_CTRL[11:2]);
    assign hit_file = (aw_addr_q[11:9] == rss_pkg::FILE_WIN_SEL);
    assign wr_idx = aw_addr_q[8:2];
    assign wr_hit = hit_instr | hit_acc | hit_status | hit_wdog | hit_ctrl | hit_file;

    // a sleeping core executes nothing; the word is still acknowledged
    assign exec_valid = do_write && hit_instr && (core_state == rss_pkg::core_run);
    assign exec_op = rss_pkg::rss_op_t'(wr_word[rss_pkg::OP_LSB +: 3]);
    assign exec_dest = wr_word[rss_pkg::DEST_BIT];
    assign exec_faddr = wr_word[rss_pkg::FADDR_LSB +: 7];
    assign exec_lit = wr_word[rss_pkg::LIT_LSB +: 8];
    assign exec_rotate = (exec_op == rss_pkg::rotate_left_carry_op) ||
                         (exec_op == rss_pkg::rotate_right_carry_op);

    rss_alu u_alu (
        .op(exec_op),
        .file_val(file_reg[exec_faddr]),
        .acc(acc),
        .literal(exec_lit),
        .carry_in(status[rss_pkg::ST_CARRY]),
        .result(alu_result),
        .carry_out(alu_carry),
        .nibble_carry(alu_nibble),
        .zero(alu_zero)
    );

    // ======================================================================
    // write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= !aw_held && !(awvalid && awready) && !bvalid && !do_write;
            wready <= !w_held && !(wvalid && wready) && !bvalid && !do_write;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= rss_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // ======================================================================
    // read channel: one read in flight, data registered
    assign rd_take = arvalid && arready;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (araddr[11:9] == rss_pkg::FILE_WIN_SEL) begin
            rd_mux[7:0] = file_reg[araddr[8:2]];
        end else begin
            case (araddr[11:2])
                rss_pkg::OFF_INSTR[11:2]: rd_mux = 32'h0000_0000;
                rss_pkg::OFF_ACC[11:2]: rd_mux[7:0] = acc;
                rss_pkg::OFF_STATUS[11:2]: rd_mux[5:0] = {core_state == rss_pkg::core_sleep, status};
                rss_pkg::OFF_WDOG[11:2]: rd_mux[15:0] = {8'(wdog_prescaler), 8'(watchdog_counter)};
                rss_pkg::OFF_CTRL[11:2]: rd_mux[rss_pkg::CTRL_WDOG_EN] = wdog_enable;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rss_pkg::RESP_OKAY;
        end else if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else begin
            arready <= !rvalid;
        end
    end

    // ======================================================================
    // accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= rss_pkg::ACC_RST;
        end else if (exec_valid && exec_op == rss_pkg::literal_minus_acc_op) begin
            acc <= alu_result;
        end else if (exec_valid && exec_rotate && !exec_dest) begin
            acc <= alu_result;
        end else if (do_write && hit_acc) begin
            acc <= w_strb_q[0] ? w_data_q[7:0] : acc;
        end
    end

    // ======================================================================
    // file registers: one writer process per entry
    for (genvar gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                file_reg[gi] <= 8'h00;
            end else if (exec_valid && exec_rotate && exec_dest && exec_faddr == 7'(gi)) begin
                file_reg[gi] <= alu_result;
            end else if (do_write && hit_file && wr_idx == 7'(gi) && w_strb_q[0]) begin
                file_reg[gi] <= w_data_q[7:0];
            end
        end
    end

    // ======================================================================
    // status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= rss_pkg::STATUS_RST;
        end else if (exec_valid) begin
            case (exec_op)
                rss_pkg::rotate_left_carry_op, rss_pkg::rotate_right_carry_op: begin
                    status[rss_pkg::ST_CARRY] <= alu_carry;
                end
                rss_pkg::literal_minus_acc_op: begin
                    status[rss_pkg::ST_CARRY] <= alu_carry;
                    status[rss_pkg::ST_NIBBLE] <= alu_nibble;
                    status[rss_pkg::ST_ZERO] <= alu_zero;
                end
                rss_pkg::power_down_op: begin
                    status[rss_pkg::ST_PWRDN] <= 1'b0;
                    status[rss_pkg::ST_TMOUT] <= 1'b1;
                end
                default: begin
                    status <= status;
                end
            endcase
        end else if (do_write && hit_status && w_strb_q[0]) begin
            status <= w_data_q[4:0];
        end
    end

    // ======================================================================
    // watchdog and prescaler, on aclk and gated only by the enable bit, so they run in sleep too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdog_enable <= 1'b0;
        end else if (do_write && hit_ctrl && w_strb_q[0]) begin
            wdog_enable <= w_data_q[rss_pkg::CTRL_WDOG_EN];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_counter <= '0;
            wdog_prescaler <= '0;
        end else if (exec_valid && exec_op == rss_pkg::power_down_op) begin
            watchdog_counter <= '0;
            wdog_prescaler <= '0;
        end else if (wdog_enable) begin
            wdog_prescaler <= wdog_prescaler + 1'b1;
            if (&wdog_prescaler) begin
                watchdog_counter <= watchdog_counter + 1'b1;
            end
        end
    end

    // ======================================================================
    // power state; flags settle on the same edge the core stops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_state <= rss_pkg::core_run;
        end else begin
            case (core_state)
                rss_pkg::core_run: begin
                    if (exec_valid && exec_op == rss_pkg::power_down_op) begin
                        core_state <= rss_pkg::core_sleep;
                    end
                end
                rss_pkg::core_sleep: begin
                    if (do_write && hit_ctrl && w_strb_q[0] && w_data_q[rss_pkg::CTRL_WAKE]) begin
                        core_state <= rss_pkg::core_run;
                    end
                end
                default: begin
                    core_state <= rss_pkg::core_run;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_sleeping <= 1'b0;
            osc_enable <= 1'b1;
        end else if (exec_valid && exec_op == rss_pkg::power_down_op) begin
            core_sleeping <= 1'b1;
            osc_enable <= 1'b0;
        end else if (core_state == rss_pkg::core_sleep && do_write && hit_ctrl && w_strb_q[0] &&
                     w_data_q[rss_pkg::CTRL_WAKE]) begin
            core_sleeping <= 1'b0;
            osc_enable <= 1'b1;
        end
    end
endmodule : rss_exec
`default_nettype wire

/* File: verif/rss_exec_assertions.sv */
// port-level checks of the rotate, subtract and power-down unit
`timescale 1ns/1ps
`default_nettype none
module rss_exec_assertions (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // read side
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // power state
    input wire logic core_sleeping,
    input wire logic osc_enable
);
    // ======================================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    osc_halted_a: assert property (core_sleeping == !osc_enable)
        else $error("oscillator enable disagrees with sleep state");
    sleep_entry_a: assert property ($rose(core_sleeping) |-> $rose(bvalid))
        else $error("sleep entered outside a write response");
    sleep_exit_a: assert property ($fell(core_sleeping) |-> $rose(bvalid))
        else $error("sleep left outside a write response");
    write_answer_a: assert property (awvalid && awready && wvalid && wready |-> !bvalid ##1 !bvalid ##1 bvalid)
        else $error("write response not two cycles after handshake");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped before rready");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one cycle after address");
    write_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write channels open while response pending");
    read_busy_a: assert property (rvalid |-> !arready)
        else $error("read address open while data pending");
    reset_idle_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && osc_enable && !core_sleeping)
        else $error("outputs not idle after reset");
endmodule : rss_exec_assertions

bind rss_exec rss_exec_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .core_sleeping(core_sleeping), .osc_enable(osc_enable));
`default_nettype wire

/* File: verif/rss_exec_bench.sv */
// self-checking bench of the execution unit over its register bus
`timescale 1ns/1ps
`default_nettype none
module rss_exec_bench;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, core_sleeping, osc_enable;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_fail, n_tests;

    rss_exec dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .core_sleeping(core_sleeping), .osc_enable(osc_enable));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ======================================================================
    // compare and bus tasks
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_resp

    task automatic bus_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check_resp("bresp", er, bresp);
    endtask : bus_write

    task automatic bus_read(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        check_resp("rresp", er, rresp);
    endtask : bus_read

    task automatic expect_reg(input string what, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] got;
        bus_read(a, got, rss_pkg::RESP_OKAY);
        check_word(what, e, got);
    endtask : expect_reg

    task automatic exec_instr(input logic [2:0] op, input logic d, input logic [6:0] fa, input logic [7:0] k);
        bus_write(rss_pkg::OFF_INSTR, {8'h00, k, 1'b0, fa, d, 4'h0, op}, rss_pkg::RESP_OKAY);
    endtask : exec_instr

    function automatic logic [11:0] faddr(input logic [6:0] fa);
        return 12'h200 + {3'h0, fa, 2'h0};
    endfunction : faddr

    // ======================================================================
    // scenarios
    task automatic t_reset;
        expect_reg("status", rss_pkg::OFF_STATUS, 32'h18);
        expect_reg("acc", rss_pkg::OFF_ACC, 32'h0);
        expect_reg("watchdog", rss_pkg::OFF_WDOG, 32'h0);
        expect_reg("ctrl", rss_pkg::OFF_CTRL, 32'h0);
        expect_reg("file", faddr(7'h7f), 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_rotate;
        logic [7:0] v, ef;
        logic [6:0] fa;
        logic [2:0] op;
        logic c, d, ec;
        for (int i = 0; i < 16; i++) begin
            op = i[3] ? rss_pkg::rotate_right_carry_op : rss_pkg::rotate_left_carry_op;
            v = i[0] ? 8'h19 : 8'he6;
            fa = i[0] ? 7'h7f : 7'h00;
            c = i[1];
            d = i[2];
            bus_write(faddr(fa), {24'h0, v}, rss_pkg::RESP_OKAY);
            bus_write(rss_pkg::OFF_ACC, 32'h5a, rss_pkg::RESP_OKAY);
            // nibble carry and zero preset high so a stray update shows
            bus_write(rss_pkg::OFF_STATUS, {27'h0, 4'hf, c}, rss_pkg::RESP_OKAY);
            exec_instr(op, d, fa, 8'h00);
            ef = i[3] ? {c, v[7:1]} : {v[6:0], c};
            ec = i[3] ? v[0] : v[7];
            expect_reg("acc", rss_pkg::OFF_ACC, d ? 32'h5a : {24'h0, ef});
            expect_reg("file", faddr(fa), {24'h0, d ? ef : v});
            expect_reg("status", rss_pkg::OFF_STATUS, {27'h0, 4'hf, ec});
        end
        $display("rotate test done");
    endtask : t_rotate

    task automatic t_sub;
        logic [15:0] tbl [7] = '{16'h1010, 16'h1110, 16'h0f10, 16'hff00, 16'h00ff, 16'h2345, 16'h8f80};
        logic [7:0] a, k, r;
        for (int i = 0; i < 7; i++) begin
            a = tbl[i][15:8];
            k = tbl[i][7:0];
            r = k - a;
            bus_write(rss_pkg::OFF_ACC, {24'h0, a}, rss_pkg::RESP_OKAY);
            bus_write(rss_pkg::OFF_STATUS, 32'h18, rss_pkg::RESP_OKAY);
            exec_instr(rss_pkg::literal_minus_acc_op, 1'b0, 7'h00, k);
            expect_reg("acc", rss_pkg::OFF_ACC, {24'h0, r});
            expect_reg("status", rss_pkg::OFF_STATUS,
                {27'h0, 2'h3, r == 8'h00, a[3:0] <= k[3:0], a <= k});
        end
        $display("subtract test done");
    endtask : t_sub

    task automatic t_sleep;
        logic [31:0] got;
        bus_write(rss_pkg::OFF_CTRL, 32'h1, rss_pkg::RESP_OKAY);
        repeat (300) @(posedge aclk);
        // frozen so the cleared count stays readable
        bus_write(rss_pkg::OFF_CTRL, 32'h0, rss_pkg::RESP_OKAY);
        bus_read(rss_pkg::OFF_WDOG, got, rss_pkg::RESP_OKAY);
        check_word("watchdog running", 32'h1, {31'h0, got != 32'h0});
        bus_write(rss_pkg::OFF_STATUS, 32'h0d, rss_pkg::RESP_OKAY);
        exec_instr(rss_pkg::power_down_op, 1'b0, 7'h00, 8'h00);
        check_word("sleeping", 32'h1, {31'h0, core_sleeping});
        check_word("osc", 32'h0, {31'h0, osc_enable});
        expect_reg("status", rss_pkg::OFF_STATUS, 32'h35);
        expect_reg("watchdog", rss_pkg::OFF_WDOG, 32'h0);
        bus_write(rss_pkg::OFF_ACC, 32'h33, rss_pkg::RESP_OKAY);
        exec_instr(rss_pkg::literal_minus_acc_op, 1'b0, 7'h00, 8'h44);
        expect_reg("acc asleep", rss_pkg::OFF_ACC, 32'h33);
        bus_write(rss_pkg::OFF_CTRL, 32'h2, rss_pkg::RESP_OKAY);
        check_word("osc", 32'h1, {31'h0, osc_enable});
        expect_reg("status", rss_pkg::OFF_STATUS, 32'h15);
        $display("sleep test done");
    endtask : t_sleep

    task automatic t_err;
        logic [31:0] got;
        bus_write(12'h100, 32'h1, rss_pkg::RESP_SLVERR);
        bus_read(12'h100, got, rss_pkg::RESP_SLVERR);
        check_word("unmapped", 32'h0, got);
        // undefined op code must leave the accumulator alone
        exec_instr(3'h7, 1'b1, 7'h00, 8'h12);
        expect_reg("acc no-op", rss_pkg::OFF_ACC, 32'h33);
        wstrb <= 4'he;
        bus_write(rss_pkg::OFF_ACC, 32'h77, rss_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        expect_reg("acc lane", rss_pkg::OFF_ACC, 32'h33);
        $display("error test done");
    endtask : t_err

    // ======================================================================
    // sequence and verdict
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, awprot, arprot, wdata} = '0;
        wstrb = 4'hf;
        n_fail = 0;
        n_tests = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_rotate();
        t_sub();
        t_sleep();
        t_err();
        test_done();
    end

    // roughly twenty times the expected run
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
endmodule : rss_exec_bench
`default_nettype wire
